// >>> icm_pkg.sv
// constants shared by the i2c master command engine
package icm_pkg;
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_STOP = 2'h2;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_FREQ_KHZ = 100;
    localparam int SCL_QUARTER_NS = 1000000 / (SCL_FREQ_KHZ * 4);
    localparam int QUARTER_CYC_INT = SCL_QUARTER_NS / CLK_PERIOD_NS;
    localparam logic [8:0] QUARTER_CYC = QUARTER_CYC_INT[8:0];
    localparam int MEM_DEPTH = 256;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_WIDTH = 8;
    localparam logic [3:0] ACK_BIT_IDX = 4'h8;
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BIT, ST_STOP} icm_state_t;
    typedef enum logic [1:0] {BY_ADDR, BY_TX, BY_RX} icm_kind_t;
endpackage : icm_pkg

// >>> icm_command_engine.sv
// i2c master command engine with receive fifo and data memory array
`timescale 1ns/100ps

module icm_rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [AW:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
    logic full, empty;
    assign full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
    assign empty = wrPtr_r == rdPtr_r;
    assign inReady = !full;
    assign outValid = !empty;
    assign outData = store[rdPtr_r[AW-1:0]];
    always_comb begin
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        if (inValid && !full) begin
            wrPtr_nxt = wrPtr_r + 1'b1;
        end
        if (outReady && !empty) begin
            rdPtr_nxt = rdPtr_r + 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (inValid && !full) begin
            store[wrPtr_r[AW-1:0]] <= inData;
        end
    end
endmodule : icm_rx_fifo

module icm_command_engine (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cmdValid,
    input wire logic [1:0] cmdOp,
    input wire logic [6:0] target_address_operand,
    input wire logic [7:0] cmdStartIdx,
    input wire logic [8:0] cmdCount,
    output logic cmdReady,
    output logic busy,
    output logic ackOk,
    output logic busOpen,
    output logic doneStb,
    input wire logic memWrEn,
    input wire logic [7:0] memWrIdx,
    input wire logic [7:0] memWrData,
    input wire logic [7:0] memRdIdx,
    output logic [7:0] memRdData,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe
);
    import icm_pkg::*;
    logic [7:0] data_memory_array [0:MEM_DEPTH-1];
    logic [1:0] sclSync_r, sdaSync_r;
    icm_state_t state_r, state_nxt;
    icm_kind_t kind_r, kind_nxt;
    logic [1:0] phase_r, phase_nxt;
    logic [8:0] qcnt_r, qcnt_nxt;
    logic [3:0] bitIdx_r, bitIdx_nxt;
    logic [7:0] ptr_r, ptr_nxt, shift_r, shift_nxt;
    logic [8:0] remain_r, remain_nxt;
    logic isRead_r, isRead_nxt, nack_r, nack_nxt;
    logic ackOk_r, ackOk_nxt, busOpen_r, busOpen_nxt, done_r, done_nxt;
    logic sclHi_r, sclHi_nxt, sdaHi_r, sdaHi_nxt;
    logic [7:0] drainIdx_r, drainIdx_nxt, memRd_r;
    logic tick, advance, pushRx, fifoInReady, fifoOutValid, fifoOutReady;
    logic [7:0] fifoOutData;
    logic lastByte;
    // first stage feeds only the second stage
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sclSync_r <= 2'h3;
            sdaSync_r <= 2'h3;
        end else begin
            sclSync_r <= {sclSync_r[0], sclIn};
            sdaSync_r <= {sdaSync_r[0], sdaIn};
        end
    end
    icm_rx_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) rxFifo (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .inValid(pushRx),
        .inReady(fifoInReady),
        .inData(shift_r),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );
    // software writes win the memory port; the fifo waits until memWrEn drops
    assign fifoOutReady = !memWrEn;
    assign busy = (state_r != ST_IDLE) || fifoOutValid;
    assign cmdReady = !busy;
    assign lastByte = remain_r == 9'h001;
    assign tick = qcnt_r == QUARTER_CYC - 9'h001;
    // a target holding the clock low stretches the high phase
    // a full fifo holds the clock low before the ack slot
    assign pushRx = tick && state_r == ST_BIT && kind_r == BY_RX && bitIdx_r == ACK_BIT_IDX && phase_r == 2'h0;
    assign advance = tick && !(phase_r == 2'h1 && !sclSync_r[1]) && !(pushRx && !fifoInReady);
    always_comb begin
        state_nxt = state_r;
        kind_nxt = kind_r;
        phase_nxt = phase_r;
        qcnt_nxt = (state_r == ST_IDLE || tick) ? 9'h000 : qcnt_r + 9'h001;
        bitIdx_nxt = bitIdx_r;
        ptr_nxt = ptr_r;
        shift_nxt = shift_r;
        remain_nxt = remain_r;
        isRead_nxt = isRead_r;
        nack_nxt = nack_r;
        ackOk_nxt = ackOk_r;
        busOpen_nxt = busOpen_r;
        done_nxt = 1'b0;
        drainIdx_nxt = drainIdx_r;
        if (fifoOutValid && fifoOutReady) begin
            drainIdx_nxt = drainIdx_r + 8'h01;
        end
        case (state_r)
            ST_IDLE: begin
                phase_nxt = 2'h0;
                if (cmdValid) begin
                    if (cmdOp == OP_STOP) begin
                        state_nxt = ST_STOP;
                    end else if (cmdOp == OP_WRITE || cmdOp == OP_READ) begin
                        state_nxt = ST_START;
                        isRead_nxt = cmdOp == OP_READ;
                        shift_nxt = {target_address_operand, cmdOp == OP_READ};
                        ptr_nxt = cmdStartIdx;
                        drainIdx_nxt = cmdStartIdx;
                        remain_nxt = cmdCount;
                        ackOk_nxt = 1'b0;
                    end
                end
            end
            ST_START: begin
                if (advance) begin
                    phase_nxt = phase_r + 2'h1;
                    if (phase_r == 2'h3) begin
                        state_nxt = ST_BIT;
                        kind_nxt = BY_ADDR;
                        bitIdx_nxt = 4'h0;
                        busOpen_nxt = 1'b1;
                    end
                end
            end
            ST_BIT: begin
                if (advance) begin
                    phase_nxt = phase_r + 2'h1;
                    if (phase_r == 2'h2) begin
                        if (bitIdx_r == ACK_BIT_IDX) begin
                            nack_nxt = sdaSync_r[1];
                        end else if (kind_r == BY_RX) begin
                            shift_nxt = {shift_r[6:0], sdaSync_r[1]};
                        end
                    end
                    if (phase_r == 2'h3) begin
                        bitIdx_nxt = bitIdx_r + 4'h1;
                        if (kind_r != BY_RX && bitIdx_r < 4'h7) begin
                            shift_nxt = {shift_r[6:0], 1'b1};
                        end
                        if (bitIdx_r == ACK_BIT_IDX) begin
                            bitIdx_nxt = 4'h0;
                            if (kind_r != BY_RX && nack_r) begin
                                state_nxt = ST_STOP;
                                ackOk_nxt = 1'b0;
                            end else if (kind_r == BY_RX) begin
                                ptr_nxt = ptr_r + 8'h01;
                                remain_nxt = remain_r - 9'h001;
                                if (lastByte) begin
                                    state_nxt = ST_STOP;
                                    ackOk_nxt = 1'b1;
                                end
                            end else begin
                                if (kind_r == BY_TX) begin
                                    ptr_nxt = ptr_r + 8'h01;
                                    remain_nxt = remain_r - 9'h001;
                                end
                                if ((kind_r == BY_TX && lastByte) || remain_r == 9'h000) begin
                                    state_nxt = ST_IDLE;
                                    ackOk_nxt = 1'b1;
                                    done_nxt = 1'b1;
                                end else if (isRead_r) begin
                                    kind_nxt = BY_RX;
                                    shift_nxt = 8'hff;
                                end else begin
                                    kind_nxt = BY_TX;
                                    shift_nxt = data_memory_array[kind_r == BY_TX ? ptr_r + 8'h01 : ptr_r];
                                end
                            end
                        end
                    end
                end
            end
            ST_STOP: begin
                if (advance) begin
                    phase_nxt = phase_r + 2'h1;
                    if (phase_r == 2'h3) begin
                        state_nxt = ST_IDLE;
                        busOpen_nxt = 1'b0;
                        done_nxt = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // line levels follow the next phase so they come straight from flops
        case (state_nxt)
            ST_START: begin
                sclHi_nxt = phase_nxt == 2'h1 || phase_nxt == 2'h2;
                sdaHi_nxt = phase_nxt < 2'h2;
            end
            ST_BIT: begin
                sclHi_nxt = phase_nxt == 2'h1 || phase_nxt == 2'h2;
                if (bitIdx_nxt == ACK_BIT_IDX) begin
                    sdaHi_nxt = kind_nxt == BY_RX ? remain_nxt == 9'h001 : 1'b1;
                end else begin
                    sdaHi_nxt = kind_nxt == BY_RX ? 1'b1 : shift_nxt[7];
                end
            end
            ST_STOP: begin
                sclHi_nxt = phase_nxt != 2'h0;
                sdaHi_nxt = phase_nxt[1];
            end
            default: begin
                sclHi_nxt = !busOpen_nxt;
                sdaHi_nxt = !busOpen_nxt || sdaHi_r;
            end
        endcase
        // data waits a cycle after the clock falls, else targets may see a false start or stop
        if (sclHi_r && !sclHi_nxt) begin
            sdaHi_nxt = sdaHi_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            kind_r <= BY_ADDR;
            phase_r <= 2'h0;
            qcnt_r <= 9'h000;
            bitIdx_r <= 4'h0;
            ptr_r <= 8'h00;
            shift_r <= 8'h00;
            remain_r <= 9'h000;
            isRead_r <= 1'b0;
            nack_r <= 1'b0;
            ackOk_r <= 1'b0;
            busOpen_r <= 1'b0;
            done_r <= 1'b0;
            sclHi_r <= 1'b1;
            sdaHi_r <= 1'b1;
            drainIdx_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            phase_r <= phase_nxt;
            qcnt_r <= qcnt_nxt;
            bitIdx_r <= bitIdx_nxt;
            ptr_r <= ptr_nxt;
            shift_r <= shift_nxt;
            remain_r <= remain_nxt;
            isRead_r <= isRead_nxt;
            nack_r <= nack_nxt;
            ackOk_r <= ackOk_nxt;
            busOpen_r <= busOpen_nxt;
            done_r <= done_nxt;
            sclHi_r <= sclHi_nxt;
            sdaHi_r <= sdaHi_nxt;
            drainIdx_r <= drainIdx_nxt;
        end
    end

    // memory has no reset; contents are software's business
    always_ff @(posedge sys_clk) begin
        if (memWrEn) begin
            data_memory_array[memWrIdx] <= memWrData;
        end else if (fifoOutValid) begin
            data_memory_array[drainIdx_r] <= fifoOutData;
        end
        memRd_r <= data_memory_array[memRdIdx];
    end

    assign memRdData = memRd_r;
    assign ackOk = ackOk_r;
    assign busOpen = busOpen_r;
    assign doneStb = done_r;
    // open drain: only ever pull low
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;
    assign sclOe = !sclHi_r;
    assign sdaOe = !sdaHi_r;
endmodule : icm_command_engine

// >>> icm_command_engine_monitor.sv
// assertion checker watching the command engine ports
`timescale 1ns/100ps
module icm_command_engine_monitor (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cmdValid,
    input wire logic [1:0] cmdOp,
    input wire logic cmdReady,
    input wire logic busy,
    input wire logic ackOk,
    input wire logic busOpen,
    input wire logic doneStb,
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic sdaOut,
    input wire logic sdaOe
);
    import icm_pkg::*;
    logic xferTake;
    assign xferTake = cmdValid && cmdReady && (cmdOp == OP_WRITE || cmdOp == OP_READ);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    AST_PINS_OPEN_DRAIN: assert property (!sclOut && !sdaOut)
        else $error("pin data not held low");
    AST_READY_IS_IDLE: assert property (!busy && !cmdValid |=> cmdReady && !busy)
        else $error("ready does not mirror busy");
    AST_ACK_CLEARED: assert property (xferTake |=> !ackOk)
        else $error("ack flag not cleared on new transfer");
    AST_ACK_HELD: assert property (!busy && !xferTake |=> $stable(ackOk))
        else $error("ack flag moved while idle");
    AST_DONE_ONE_CYCLE: assert property (doneStb |=> !doneStb)
        else $error("done pulse longer than one cycle");
    AST_TAKE_STARTS: assert property (cmdValid && cmdReady && cmdOp != 2'h3 |=> busy)
        else $error("accepted command did not start");
    AST_OPEN_HOLDS_SCL: assert property (busOpen && !busy |-> sclOe)
        else $error("open bus idle without clock held low");
    AST_STOP_RELEASES: assert property ($fell(busOpen) |-> ##[0:2] (!sclOe && !sdaOe))
        else $error("lines not released after stop");
    AST_START_SCL_LOW: assert property ($rose(busOpen) |-> sclOe)
        else $error("start did not end with clock low");
    AST_IDLE_QUIET: assert property (!busy && !cmdValid |=> $stable(sclOe) && $stable(sdaOe))
        else $error("bus activity without a command");
    AST_DONE_THEN_READY: assert property (doneStb |-> ##[0:40] cmdReady)
        else $error("engine not ready after done");
    // three main outcomes: write left open, transfer closed with ack, nack
    cover property (doneStb && busOpen);
    cover property (doneStb && !busOpen && ackOk);
    cover property (doneStb && !ackOk);
endmodule : icm_command_engine_monitor

bind icm_command_engine icm_command_engine_monitor u_mon (.sys_clk(sys_clk), .nrst(nrst), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdReady(cmdReady), .busy(busy), .ackOk(ackOk), .busOpen(busOpen), .doneStb(doneStb),
    .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe));

// >>> icm_eeprom_model.sv
// behavioural serial eeprom target on the two-wire bus
`timescale 1ns/100ps
module icm_eeprom_model #(
    parameter bit SECOND_FITTED = 1'b0
) (
    input wire logic scl,
    input wire logic sda,
    output logic sdaPull
);
    logic [7:0] mem [256];
    logic [7:0] shReg;
    logic [7:0] txByte;
    logic [15:0] ptr = 16'h0000;
    int bitCnt = 0;
    int byteCnt = 0;
    logic active = 1'b0;
    logic reading = 1'b0;
    initial begin
        sdaPull = 1'b0;
        for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
    end
    // start resets framing; the first scl fall belongs to the start itself
    always @(negedge sda) if (scl === 1'b1) begin
        active = 1'b1;
        bitCnt = -1;
        byteCnt = 0;
        reading = 1'b0;
    end
    always @(posedge sda) if (scl === 1'b1) begin
        active = 1'b0;
        sdaPull = 1'b0;
    end
    always @(posedge scl) if (active) begin
        if (bitCnt < 8) shReg = {shReg[6:0], sda};
        else if (reading && byteCnt > 0 && sda) active = 1'b0;
    end
    always @(negedge scl) if (active) begin
        sdaPull = 1'b0;
        bitCnt = bitCnt + 1;
        if (bitCnt == 8) begin
            if (byteCnt == 0) begin
                reading = shReg[0];
                active = shReg[7:3] == 5'h14 && (SECOND_FITTED || !shReg[2]);
                sdaPull = active;
            end else if (!reading) begin
                sdaPull = 1'b1;
                if (byteCnt == 1) ptr[15:8] = shReg;
                else if (byteCnt == 2) ptr[7:0] = shReg;
                else begin
                    mem[ptr[7:0]] = shReg;
                    ptr[7:0] = ptr[7:0] + 8'h01;
                end
            end
        end else if (bitCnt == 9) begin
            bitCnt = 0;
            byteCnt++;
            if (reading) begin
                txByte = mem[ptr[7:0]];
                ptr = ptr + 16'h0001;
            end
        end
        if (reading && byteCnt > 0 && bitCnt < 8) sdaPull = !txByte[7 - bitCnt];
    end
endmodule : icm_eeprom_model

// >>> icm_command_engine_tb_top.sv
// self-checking bench for the i2c master command engine
`timescale 1ns/100ps
module icm_command_engine_tb_top;
    import icm_pkg::*;
    typedef struct packed {logic [1:0] op; logic [6:0] adr; logic [7:0] st; logic [8:0] cnt; logic ack;
        logic open;} icm_row_t;
    logic sys_clk, nrst, cmdValid, memWrEn, cmdReady, busy, ackOk, busOpen, doneStb;
    logic sclOut, sclOe, sdaOut, sdaOe, sdaPull, sclLine, sdaLine;
    logic [1:0] cmdOp;
    logic [6:0] tgtAdr;
    logic [7:0] cmdStartIdx, memWrIdx, memWrData, memRdIdx, memRdData;
    logic [8:0] cmdCount;
    int fails = 0;
    int checked = 0;
    // pointer-setting write, stop, read from that pointer, write to an absent target
    icm_row_t rows [4] = '{'{OP_WRITE, 7'h50, 8'h10, 9'h002, 1'b1, 1'b1}, '{OP_STOP, 7'h00, 8'h00, 9'h000, 1'b1, 1'b0},
        '{OP_READ, 7'h50, 8'h40, 9'h002, 1'b1, 1'b0}, '{OP_WRITE, 7'h52, 8'h10, 9'h001, 1'b0, 1'b0}};
    // pull-ups on both lines; the target model never stretches the clock
    assign sclLine = !sclOe;
    assign sdaLine = !(sdaOe || sdaPull);
    icm_command_engine u_dut (.sys_clk(sys_clk), .nrst(nrst), .cmdValid(cmdValid), .cmdOp(cmdOp),
        .target_address_operand(tgtAdr), .cmdStartIdx(cmdStartIdx), .cmdCount(cmdCount), .cmdReady(cmdReady),
        .busy(busy), .ackOk(ackOk), .busOpen(busOpen), .doneStb(doneStb), .memWrEn(memWrEn), .memWrIdx(memWrIdx),
        .memWrData(memWrData), .memRdIdx(memRdIdx), .memRdData(memRdData), .sclIn(sclLine), .sclOut(sclOut),
        .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe));
    icm_eeprom_model u_eeprom (.scl(sclLine), .sda(sdaLine), .sdaPull(sdaPull));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize;
        if (fails == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic runCmd(input icm_row_t r, input bit waitDone);
        int n;
        n = 0;
        while (cmdReady !== 1'b1) begin
            @(negedge sys_clk);
            n++;
            if (n > 100) begin fails++; summarize(); end
        end
        @(posedge sys_clk);
        cmdValid <= 1'b1;
        cmdOp <= r.op;
        tgtAdr <= r.adr;
        cmdStartIdx <= r.st;
        cmdCount <= r.cnt;
        @(posedge sys_clk);
        cmdValid <= 1'b0;
        n = 0;
        while (waitDone && doneStb !== 1'b1) begin
            @(negedge sys_clk);
            n++;
            if (n > 50000) begin fails++; summarize(); end
        end
    endtask : runCmd
    task automatic memCheck(input logic [7:0] idx, input logic [7:0] exp);
        @(posedge sys_clk);
        memRdIdx <= idx;
        @(posedge sys_clk);
        @(negedge sys_clk);
        check(memRdData, exp);
    endtask : memCheck
    initial begin
        {nrst, cmdValid, memWrEn, cmdOp, tgtAdr, cmdStartIdx, cmdCount, memWrIdx, memWrData, memRdIdx} = '0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        @(negedge sys_clk);
        check({7'h00, cmdReady}, 8'h01);
        check({4'h0, ackOk, busOpen, sclOe, sdaOe}, 8'h00);
        @(posedge sys_clk);
        memWrEn <= 1'b1;
        memWrIdx <= 8'h11;
        memWrData <= 8'h12;
        @(posedge sys_clk);
        memWrIdx <= 8'h10;
        memWrData <= 8'h00;
        @(posedge sys_clk);
        memWrEn <= 1'b0;
        foreach (rows[i]) begin
            runCmd(rows[i], 1'b1);
            @(negedge sys_clk);
            check({7'h00, ackOk}, {7'h00, rows[i].ack});
            check({7'h00, busOpen}, {7'h00, rows[i].open});
        end
        memCheck(8'h40, 8'h48);
        memCheck(8'h41, 8'h49);
        // reset in mid-frame must free both lines at once
        runCmd(rows[0], 1'b0);
        repeat (2000) @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        @(negedge sys_clk);
        check({4'h0, cmdReady, busOpen, sclOe, sdaOe}, 8'h08);
        check({7'h00, ackOk}, 8'h00);
        // the unused operation code must be ignored
        @(posedge sys_clk);
        cmdValid <= 1'b1;
        cmdOp <= 2'h3;
        @(posedge sys_clk);
        cmdValid <= 1'b0;
        @(negedge sys_clk);
        check({6'h00, busy, busOpen}, 8'h00);
        summarize();
    end
endmodule : icm_command_engine_tb_top
